/* rtl/wdt_pkg.sv */
/*
 * Package of the watchdog timer: register map, field layout, reset values,
 * timing constants and the carrier types shared by the design and bench.
 * Assumes a 10 MHz system clock and a 32-bit byte address on the
 * register port with 16-bit data.
 */
package wdt_pkg;

	// ==========================================================
	// Register map (byte addresses).
	// ==========================================================
	localparam logic [31:0] COUNT_ADDR      = 32'h5000_3100;
	localparam logic [31:0] CONTROL_ADDR    = 32'h5000_3102;
	localparam logic [31:0] IRQ_STATUS_ADDR = 32'h5000_3110;
	localparam logic [31:0] IRQ_MASK_ADDR   = 32'h5000_3112;
	localparam logic [31:0] FRZ_SET_ADDR    = 32'h5000_3300;
	localparam logic [31:0] FRZ_CLEAR_ADDR  = 32'h5000_3302;

	// ==========================================================
	// Field layout.
	// ==========================================================
	localparam int KEY_MSB        = 15;
	localparam int KEY_LSB        = 9;
	localparam int SIGN_POS       = 8;
	localparam int VALUE_MSB      = 7;
	localparam int MODE_POS       = 0;
	localparam int FREEZE_DOG_POS = 3;
	localparam int EV_NMI_POS     = 0;
	localparam int EV_RST_POS     = 1;
	localparam int EV_REJECT_POS  = 2;

	// ==========================================================
	// Reset values and counter landmarks.
	// ==========================================================
	localparam logic [8:0] COUNT_RESET = 9'h0FF;
	localparam logic [8:0] COUNT_RELOAD = 9'h0FF;
	localparam logic [8:0] COUNT_ZERO  = 9'h000;
	localparam logic [8:0] COUNT_LIMIT = 9'h1F0;
	localparam logic [6:0] KEY_OPEN    = 7'h00;
	localparam logic [2:0] EV_RESET    = 3'h0;
	localparam logic [2:0] MASK_RESET  = 3'h0;

	// ==========================================================
	// Timing.
	// ==========================================================
	localparam int CLK_PERIOD_NS = 100;
	localparam int INTERVAL_NS   = 10_240_000;
	localparam int TICK_CYCLES   = INTERVAL_NS / CLK_PERIOD_NS;
	localparam int PRESC_W       = 17;

	// ==========================================================
	// Carrier types.
	// ==========================================================
	typedef struct packed {
		logic [31:0] addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} wdt_bus_req_t;

	typedef struct packed {
		logic       freeze_set;
		logic       freeze_clear;
		logic       debug_halt;
	} wdt_hold_t;

endpackage : wdt_pkg

/* rtl/wdt_core.sv */
/*
 * Watchdog timer: 9-bit signed down-counter with key-filtered reload,
 * interrupt or reset on expiry, freeze controls and an event interrupt.
 * Assumes a register master that issues one-cycle strobes and takes read
 * data in the cycle after the read strobe; inputs are synchronous.
 */
// Contract
// (R1) Reload accepted only with key bits zero.
// (R2) Key field always reads back as zero.
// (R3) Accepted write loads low eight bits.
// (R4) Read returns live count; reset 0xFF.
// (R5) Decrement by one every 10.24 ms.
// (R6) Nine-bit two's complement, bit eight sign.
// (R7) Mode clear: interrupt request at zero.
// (R8) Mode clear: reset at 1F0, reload FF.
// (R9) Mode set: reset at zero or below.
// (R10) Mode clear: external freeze stops, clear resumes.
// (R11) Mode set: software freeze ignored.
// (R12) Mode bit sticky; only resets clear it.
// (R13) Debug halt always freezes the counter.
// (R14) Freeze-set bit three freezes in mode clear.
// (R15) Freeze-clear bit three lets counting continue.
// (R16) Prescaler interval; outputs synchronous, one cycle.
module wdt_core #(
	parameter int TICK_CYCLES_P = wdt_pkg::TICK_CYCLES
) (
	input  wire logic                  ref_clk_in,
	input  wire logic                  rst_n_in,
	input  wire wdt_pkg::wdt_bus_req_t bus_req_in,
	input  wire wdt_pkg::wdt_hold_t    hold_in,
	output logic [15:0]                rd_data_out,
	output logic                       nmi_out,
	output logic                       wdog_rst_out,
	output logic                       irq_out
);
	import wdt_pkg::*;

	// ==========================================================
	// State.
	// ==========================================================
	typedef struct packed {
		logic [PRESC_W-1:0] presc;
		logic [8:0]         count;
		logic               mode;
		logic               frozen;
		logic [2:0]         ev;
		logic [2:0]         mask;
		logic [15:0]        rdata;
		logic               nmi;
		logic               wrst;
	} wdt_state_t;

	localparam logic [PRESC_W-1:0] TICK_LAST =
		PRESC_W'(TICK_CYCLES_P - 1);

	wdt_state_t s_r;
	wdt_state_t s_nxt;

	// ==========================================================
	// Helpers.
	// ==========================================================
	function automatic logic hit(input logic [31:0] a,
			input logic [31:0] reg_addr);
		hit = (a == reg_addr);
	endfunction : hit

	// True when the signed count is zero or negative.
	function automatic logic not_positive(input logic [8:0] c);
		not_positive = c[SIGN_POS] || (c == COUNT_ZERO);
	endfunction : not_positive

	// ==========================================================
	// Next state.
	// ==========================================================
	logic       running;
	logic       tick;
	logic       wr_count;
	logic       key_ok;
	logic       fire_rst;
	logic [2:0] ev_set;
	logic [8:0] dec;

	always_comb begin
		s_nxt  = s_r;
		ev_set = 3'h0;

		// Software freeze has no hold while the mode bit is set, and the
		// debug halt outranks every other control.
		running = !hold_in.debug_halt &&                 // [R13]
			!(s_r.frozen && !s_r.mode);                      // [R11]

		// The prescaler stops with the counter so that a resume does not
		// cut the first interval short.
		tick = 1'b0;
		if (running) begin
			if (s_r.presc == TICK_LAST) begin               // [R16]
				s_nxt.presc = '0;
				tick = 1'b1;
			end else begin
				s_nxt.presc = s_r.presc + PRESC_W'(1);
			end
		end

		dec = s_r.count - 9'h001;                         // [R6]

		fire_rst = s_r.mode ? not_positive(s_r.count)    // [R9]
			: (s_r.count == COUNT_LIMIT);                    // [R8]

		wr_count = bus_req_in.wr && hit(bus_req_in.addr, COUNT_ADDR);
		key_ok = (bus_req_in.wdata[KEY_MSB:KEY_LSB] == KEY_OPEN); // [R1]

		s_nxt.nmi  = 1'b0;
		s_nxt.wrst = 1'b0;

		if (fire_rst) begin
			// Watchdog reset: one-cycle pulse, reload and drop the mode.
			s_nxt.wrst  = 1'b1;                            // [R8] [R9]
			s_nxt.count = COUNT_RELOAD;
			s_nxt.mode  = 1'b0;                            // [R12]
			s_nxt.presc = '0;
			ev_set[EV_RST_POS] = 1'b1;
		end else if (wr_count && key_ok) begin
			// A reload wins over a tick in the same cycle.
			s_nxt.count = {1'b0,
				bus_req_in.wdata[VALUE_MSB:0]};              // [R3]
		end else if (tick) begin
			s_nxt.count = dec;                             // [R5]
			if (!s_r.mode && dec == COUNT_ZERO) begin
				s_nxt.nmi = 1'b1;                            // [R7]
				ev_set[EV_NMI_POS] = 1'b1;
			end
		end

		if (wr_count && !key_ok) begin
			ev_set[EV_REJECT_POS] = 1'b1;                  // [R1]
		end

		// ------------------------------------------------------
		// Register writes.
		// ------------------------------------------------------
		if (bus_req_in.wr) begin
			if (hit(bus_req_in.addr, CONTROL_ADDR) &&
					bus_req_in.wdata[MODE_POS] && !fire_rst) begin
				s_nxt.mode = 1'b1;                           // [R12]
			end
			if (hit(bus_req_in.addr, IRQ_MASK_ADDR)) begin
				s_nxt.mask = bus_req_in.wdata[2:0];
			end
		end

		// Freeze set and clear: external pulses or bit three writes;
		// zeros are discarded and a set is refused while the mode is on.
		if (hold_in.freeze_clear ||
				(bus_req_in.wr && hit(bus_req_in.addr, FRZ_CLEAR_ADDR) &&
				bus_req_in.wdata[FREEZE_DOG_POS])) begin
			s_nxt.frozen = 1'b0;                           // [R10] [R15]
		end
		if (!s_r.mode && (hold_in.freeze_set ||
				(bus_req_in.wr && hit(bus_req_in.addr, FRZ_SET_ADDR) &&
				bus_req_in.wdata[FREEZE_DOG_POS]))) begin
			s_nxt.frozen = 1'b1;                           // [R10] [R14]
		end
		if (s_r.mode) begin
			s_nxt.frozen = 1'b0;                           // [R11]
		end

		// Sticky events: write one clears, a new event wins.
		if (bus_req_in.wr && hit(bus_req_in.addr, IRQ_STATUS_ADDR)) begin
			s_nxt.ev = s_r.ev & ~bus_req_in.wdata[2:0];
		end
		s_nxt.ev = s_nxt.ev | ev_set;

		// ------------------------------------------------------
		// Register reads, answered in the next cycle.
		// ------------------------------------------------------
		s_nxt.rdata = 16'h0000;
		if (bus_req_in.rd) begin
			unique case (1'b1)
				hit(bus_req_in.addr, COUNT_ADDR): begin
					s_nxt.rdata = {7'h00, s_r.count};        // [R2] [R4]
				end
				hit(bus_req_in.addr, CONTROL_ADDR): begin
					s_nxt.rdata = {15'h0000, s_r.mode};
				end
				hit(bus_req_in.addr, IRQ_STATUS_ADDR): begin
					s_nxt.rdata = {13'h0000, s_r.ev};
				end
				hit(bus_req_in.addr, IRQ_MASK_ADDR): begin
					s_nxt.rdata = {13'h0000, s_r.mask};
				end
				hit(bus_req_in.addr, FRZ_SET_ADDR),
				hit(bus_req_in.addr, FRZ_CLEAR_ADDR): begin
					s_nxt.rdata = 16'(s_r.frozen) << FREEZE_DOG_POS;
				end
				default: begin
					s_nxt.rdata = 16'h0000;
				end
			endcase
		end
	end

	// ==========================================================
	// State register.
	// ==========================================================
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_r.presc  <= '0;
			s_r.count  <= COUNT_RESET;                       // [R4]
			s_r.mode   <= 1'b0;
			s_r.frozen <= 1'b0;
			s_r.ev     <= EV_RESET;
			s_r.mask   <= MASK_RESET;
			s_r.rdata  <= 16'h0000;
			s_r.nmi    <= 1'b0;
			s_r.wrst   <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// Outputs.
	// ==========================================================
	assign rd_data_out  = s_r.rdata;
	assign nmi_out      = s_r.nmi;                         // [R16]
	assign wdog_rst_out = s_r.wrst;                        // [R16]
	assign irq_out      = |(s_r.ev & s_r.mask);

endmodule : wdt_core

/* testbench/wdt_properties.sv */
/* Port checker of the watchdog timer, bound to every wdt_core.
   Assumes the bus and hold inputs are synchronous to ref_clk_in. */
module wdt_properties #(
	parameter int TICK_CYCLES_P = wdt_pkg::TICK_CYCLES
) (
	input wire logic                  ref_clk_in,
	input wire logic                  rst_n_in,
	input wire wdt_pkg::wdt_bus_req_t bus_req_in,
	input wire wdt_pkg::wdt_hold_t    hold_in,
	input wire logic [15:0]           rd_data_out,
	input wire logic                  nmi_out,
	input wire logic                  wdog_rst_out,
	input wire logic                  irq_out
);
	import wdt_pkg::*;
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	// ==========
	// Read port.
	property p_idle; !bus_req_in.rd |=> rd_data_out == 16'h0000; endproperty
	a_idle: assert property (p_idle)
		else $error("read data not zero when idle");
	property p_key;
		bus_req_in.rd && bus_req_in.addr == COUNT_ADDR |=> !(|rd_data_out[15:9]);
	endproperty
	a_key: assert property (p_key)
		else $error("key field read back nonzero");
	// Halt is required so that no tick lands between write and read.
	property p_reload;
		(bus_req_in.wr && bus_req_in.addr == COUNT_ADDR
			&& bus_req_in.wdata[15:9] == KEY_OPEN && hold_in.debug_halt)
		##1 (hold_in.debug_halt && !wdog_rst_out) ##1 (bus_req_in.rd
			&& bus_req_in.addr == COUNT_ADDR && hold_in.debug_halt
			&& !wdog_rst_out)
		|=> rd_data_out == {8'h00, $past(bus_req_in.wdata[7:0], 3)};
	endproperty
	a_reload: assert property (p_reload)
		else $error("reloaded count not read back");
	property p_reject;
		(bus_req_in.wr && bus_req_in.addr == COUNT_ADDR
			&& |bus_req_in.wdata[15:9]) ##1 !bus_req_in.wr
		##1 (bus_req_in.rd && bus_req_in.addr == IRQ_STATUS_ADDR)
		|=> rd_data_out[EV_REJECT_POS];
	endproperty
	a_reject: assert property (p_reject)
		else $error("refused reload not flagged");
	property p_mode;
		(bus_req_in.wr && bus_req_in.addr == CONTROL_ADDR
			&& bus_req_in.wdata[MODE_POS]) ##1 !wdog_rst_out
		##1 (bus_req_in.rd && bus_req_in.addr == CONTROL_ADDR
			&& !wdog_rst_out) |=> rd_data_out[MODE_POS];
	endproperty
	a_mode: assert property (p_mode)
		else $error("mode bit not set by write");

	// ==========
	// Request outputs.
	property p_nmi1; nmi_out |=> !nmi_out; endproperty
	a_nmi1: assert property (p_nmi1)
		else $error("interrupt request longer than one cycle");
	property p_rst1; wdog_rst_out |=> !wdog_rst_out; endproperty
	a_rst1: assert property (p_rst1)
		else $error("reset request longer than one cycle");
	property p_excl; !(nmi_out && wdog_rst_out); endproperty
	a_excl: assert property (p_excl)
		else $error("interrupt and reset requested together");
	// Only reset mode can follow a count into zero by a reset one cycle
	// later, and that mode must not request the interrupt on the way.
	property p_quiet; wdog_rst_out |-> !$past(nmi_out); endproperty
	a_quiet: assert property (p_quiet)
		else $error("interrupt request just before reset request");
	c_nmi: cover property (nmi_out);
	c_rst: cover property (wdog_rst_out);
	c_irq: cover property ($rose(irq_out));
endmodule : wdt_properties

bind wdt_core wdt_properties #(.TICK_CYCLES_P(TICK_CYCLES_P)) i_wdt_properties (
	.ref_clk_in  (ref_clk_in),
	.rst_n_in    (rst_n_in),
	.bus_req_in  (bus_req_in),
	.hold_in     (hold_in),
	.rd_data_out (rd_data_out),
	.nmi_out     (nmi_out),
	.wdog_rst_out(wdog_rst_out),
	.irq_out     (irq_out)
);

/* testbench/wdt_core_tb.sv */
/* Directed bench of the watchdog timer over its register port.
   Assumes wdt_pkg and the bound checker are compiled beforehand. */
module wdt_core_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import wdt_pkg::*;
	localparam int TK = 4;
	logic         ref_clk_in = 1'b0;
	logic         rst_n_in   = 1'b0;
	wdt_bus_req_t q          = '0;
	wdt_hold_t    h          = 3'h1;
	logic [15:0]  rdat;
	logic         nmi;
	logic         wrst;
	logic         irq;
	int           err_total  = 0;
	int           tests_run  = 0;
	time          t0;

	always #50 ref_clk_in = ~ref_clk_in;

	wdt_core #(.TICK_CYCLES_P(TK)) i_wdt_core (
		.ref_clk_in  (ref_clk_in),
		.rst_n_in    (rst_n_in),
		.bus_req_in  (q),
		.hold_in     (h),
		.rd_data_out (rdat),
		.nmi_out     (nmi),
		.wdog_rst_out(wrst),
		.irq_out     (irq)
	);

	// ==========
	// Bus, check, wait and report tasks.
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [31:0] a, input logic [15:0] d);
		@(posedge ref_clk_in) q <= '{a, d, 1'b1, 1'b0};
		@(posedge ref_clk_in) q <= '0;
	endtask : wr
	task automatic rd(input logic [31:0] a, input logic [15:0] e);
		@(posedge ref_clk_in) q <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge ref_clk_in) q <= '0;
		#1 chk(rdat, e);
	endtask : rd
	task automatic wt(input bit r, input int n);
		repeat (n) begin
			@(posedge ref_clk_in);
			#1;
			if ((r ? wrst : nmi) === 1'b1) break;
		end
		chk({15'h0000, r ? wrst : nmi}, 16'h0001);
	endtask : wt
	task automatic wrap_up();
		$display("checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : wrap_up

	// ==========
	// Tests; the counter is held by the debug halt until the freeze test.
	initial begin
		repeat (20) @(posedge ref_clk_in);
		rst_n_in <= 1'b1;
		rd(COUNT_ADDR, 16'h00FF);
		rd(CONTROL_ADDR, 16'h0000);
		rd(32'h5000_3104, 16'h0000);
		wr(COUNT_ADDR, 16'hFE12);
		rd(IRQ_STATUS_ADDR, 16'h0004);
		rd(COUNT_ADDR, 16'h00FF);
		wr(IRQ_STATUS_ADDR, 16'h0004);
		wr(COUNT_ADDR, 16'h0112);
		rd(COUNT_ADDR, 16'h0012);
		repeat (20) @(posedge ref_clk_in);
		rd(COUNT_ADDR, 16'h0012);
		wr(FRZ_SET_ADDR, 16'h0008);
		rd(FRZ_SET_ADDR, 16'h0008);
		@(posedge ref_clk_in) h <= 3'h0;
		repeat (12) @(posedge ref_clk_in);
		rd(COUNT_ADDR, 16'h0012);
		wr(FRZ_CLEAR_ADDR, 16'h0008);
		rd(FRZ_CLEAR_ADDR, 16'h0000);
		@(posedge ref_clk_in) h <= 3'h4;
		@(posedge ref_clk_in) h <= 3'h0;
		rd(FRZ_SET_ADDR, 16'h0008);
		@(posedge ref_clk_in) h <= 3'h2;
		@(posedge ref_clk_in) h <= 3'h0;
		rd(FRZ_SET_ADDR, 16'h0000);
		wt(1'b0, 200);
		t0 = $time;
		rd(COUNT_ADDR, 16'h0000);
		chk({15'h0000, irq}, 16'h0000);
		wr(IRQ_MASK_ADDR, 16'h0001);
		@(posedge ref_clk_in) #1 chk({15'h0000, irq}, 16'h0001);
		wr(IRQ_STATUS_ADDR, 16'h0001);
		@(posedge ref_clk_in) #1 chk({15'h0000, irq}, 16'h0000);
		wt(1'b1, 100);
		chk(16'(($time - t0) / 100), 16'(16 * TK + 1));
		rd(COUNT_ADDR, 16'h00FF);
		rd(IRQ_STATUS_ADDR, 16'h0002);
		wr(CONTROL_ADDR, 16'h0001);
		rd(CONTROL_ADDR, 16'h0001);
		wr(CONTROL_ADDR, 16'h0000);
		rd(CONTROL_ADDR, 16'h0001);
		wr(FRZ_SET_ADDR, 16'h0008);
		rd(FRZ_SET_ADDR, 16'h0000);
		@(posedge ref_clk_in) h <= 3'h1;
		wr(COUNT_ADDR, 16'h0040);
		repeat (12) @(posedge ref_clk_in);
		rd(COUNT_ADDR, 16'h0040);
		@(posedge ref_clk_in) h <= 3'h0;
		wr(COUNT_ADDR, 16'h0001);
		wt(1'b1, 8);
		rd(CONTROL_ADDR, 16'h0000);
		wr(CONTROL_ADDR, 16'h0001);
		wr(COUNT_ADDR, 16'h0000);
		wt(1'b1, 3);
		rd(CONTROL_ADDR, 16'h0000);
		wr(CONTROL_ADDR, 16'h0001);
		@(posedge ref_clk_in) rst_n_in <= 1'b0;
		repeat (2) @(posedge ref_clk_in);
		rst_n_in <= 1'b1;
		rd(CONTROL_ADDR, 16'h0000);
		rd(COUNT_ADDR, 16'h00FF);
		wrap_up();
	end

	initial begin
		#200_000;
		err_total++;
		wrap_up();
	end
endmodule : wdt_core_tb
